// ==== logic/status_pkg.sv ====
// shared constants and carrier types for the status signalling block
package status_pkg;
    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;
    // reset values of the active-low status pins (deasserted)
    localparam logic FP_PIN_RESET = 1'b1;
    localparam logic FAULT_PIN_RESET = 1'b1;
    // value driven onto an open-drain result line when asserting it
    localparam logic OD_DRIVE_LEVEL = 1'b0;
    // output enable levels (low while driving)
    localparam logic OE_ON = 1'b0;
    localparam logic OE_OFF = 1'b1;

    // snoop result the core wants to give in the current snoop phase
    typedef struct packed {
        logic stall;
        logic hit;
        logic dirty;
    } snoop_req_t;

    // open-drain drive for the share and dirty result lines
    typedef struct packed {
        logic share_out;
        logic share_oe_n;
        logic dirty_out;
        logic dirty_oe_n;
    } snoop_pins_t;

    typedef enum logic [1:0] {
        SD_IDLE,
        SD_REQ,
        SD_DONE
    } shutdown_state_t;
endpackage

// ==== logic/snoop_result_drive.sv ====
// snoop result drive and stall observation on the shared result lines
`timescale 1ns/1ps
module snoop_result_drive
    import status_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // core side
    input wire logic snoop_phase,
    input snoop_req_t snoop_req,
    output logic stall_seen,
    // result lines
    input wire logic snoop_share_in_n,
    input wire logic snoop_dirty_result_in_n,
    output snoop_pins_t pins
);
    logic [SYNC_STAGES-1:0] share_sync_q, share_sync_d;
    logic [SYNC_STAGES-1:0] dirty_sync_q, dirty_sync_d;
    // one stage longer than the pin sync: own drive reaches the line a cycle after the phase
    logic [SYNC_STAGES:0] phase_dly_q, phase_dly_d;
    logic drive_share_q, drive_share_d;
    logic drive_dirty_q, drive_dirty_d;
    logic stall_seen_q, stall_seen_d;
    logic both_low;

    // phase is delayed to line up with the synchronised pins
    always_comb begin
        share_sync_d = {share_sync_q[0], snoop_share_in_n};
        dirty_sync_d = {dirty_sync_q[0], snoop_dirty_result_in_n};
        phase_dly_d = {phase_dly_q[SYNC_STAGES-1:0], snoop_phase};
        both_low = !share_sync_q[1] && !dirty_sync_q[1];
        drive_share_d = 1'b0;
        drive_dirty_d = 1'b0;
        if (snoop_phase) begin
            // stall means both lines together
            drive_share_d = snoop_req.stall || snoop_req.hit;
            drive_dirty_d = snoop_req.stall || snoop_req.dirty;
        end
        stall_seen_d = stall_seen_q;
        // a joint assertion in each later phase keeps the stall going
        if (phase_dly_q[SYNC_STAGES]) begin
            stall_seen_d = both_low;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            share_sync_q <= '1;
            dirty_sync_q <= '1;
            phase_dly_q <= '0;
            drive_share_q <= 1'b0;
            drive_dirty_q <= 1'b0;
            stall_seen_q <= 1'b0;
        end else begin
            share_sync_q <= share_sync_d;
            dirty_sync_q <= dirty_sync_d;
            phase_dly_q <= phase_dly_d;
            drive_share_q <= drive_share_d;
            drive_dirty_q <= drive_dirty_d;
            stall_seen_q <= stall_seen_d;
        end
    end

    assign pins.share_out = OD_DRIVE_LEVEL;
    assign pins.dirty_out = OD_DRIVE_LEVEL;
    assign pins.share_oe_n = drive_share_q ? OE_ON : OE_OFF;
    assign pins.dirty_oe_n = drive_dirty_q ? OE_ON : OE_OFF;
    assign stall_seen = stall_seen_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_stall_both_lines: assert property (
        snoop_phase && snoop_req.stall |=> !pins.share_oe_n && !pins.dirty_oe_n)
        else $error("stall not driven on both result lines");
    chk_no_drive_idle: assert property (
        !snoop_phase |=> pins.share_oe_n && pins.dirty_oe_n)
        else $error("result line driven outside snoop phase");
    chk_stall_observed: assert property (
        phase_dly_q[SYNC_STAGES] && both_low |=> stall_seen)
        else $error("joint assertion not seen as stall");
    chk_stall_cleared: assert property (
        phase_dly_q[SYNC_STAGES] && !both_low |=> !stall_seen)
        else $error("stall kept without joint assertion");
    cov_stall_continued: cover property (
        stall_seen && phase_dly_q[SYNC_STAGES] && both_low);
endmodule

// ==== logic/error_snoop_status.sv ====
// processor status pins: fp error / break pending, internal fault, snoop results
// Notes on behaviour
// - one pin, meaning chosen by stop-clock request
// - stop inactive: show unmasked floating-point errors
// - stop active: show only pending break events
// - snoop stall drives share and dirty together
// - repeated joint assertion continues the stall
// - internal error condition asserts internal fault pin
// - internal fault pin held until reset
// - internal fault also requests shutdown transaction
`timescale 1ns/1ps
module error_snoop_status
    import status_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // stop-clock request pin, active low, asynchronous
    input wire logic stop_clock_request_n,
    // core event sources
    input wire logic fp_error,
    input wire logic fp_error_masked,
    input wire logic break_pending,
    input wire logic internal_error,
    // shutdown special transaction request to the bus unit
    output logic shutdown_req,
    input wire logic shutdown_ack,
    // snoop result from the core
    input wire logic snoop_phase,
    input snoop_req_t snoop_req,
    output logic snoop_stall_seen,
    // snoop result lines, open drain
    input wire logic snoop_share_in_n,
    input wire logic snoop_dirty_result_in_n,
    output snoop_pins_t snoop_pins,
    // status pins
    output logic fp_fault_break_pending_out_n,
    output logic internal_fault_out_n
);
    logic [SYNC_STAGES-1:0] stop_sync_q, stop_sync_d;
    logic stop_active;
    logic fp_unmasked;
    logic fp_pin_q, fp_pin_d;
    logic fault_q, fault_d;
    shutdown_state_t sd_q, sd_d;

    assign stop_active = !stop_sync_q[SYNC_STAGES-1];
    // a masked error never reaches the pin
    assign fp_unmasked = fp_error && !fp_error_masked;

    // pin mux, both sources sampled on the same edge
    always_comb begin
        stop_sync_d = {stop_sync_q[SYNC_STAGES-2:0], stop_clock_request_n};
        if (stop_active) begin
            fp_pin_d = !break_pending;
        end else begin
            fp_pin_d = !fp_unmasked;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stop_sync_q <= '1;
            fp_pin_q <= FP_PIN_RESET;
        end else begin
            stop_sync_q <= stop_sync_d;
            fp_pin_q <= fp_pin_d;
        end
    end

    // fault is sticky; only the asynchronous reset clears it
    always_comb begin
        fault_d = fault_q || internal_error;
        sd_d = sd_q;
        unique case (sd_q)
            SD_IDLE: begin
                if (internal_error) begin
                    sd_d = SD_REQ;
                end
            end
            SD_REQ: begin
                if (shutdown_ack) begin
                    sd_d = SD_DONE;
                end
            end
            // one shutdown per fault; further errors wait for reset
            SD_DONE: begin
                sd_d = SD_DONE;
            end
            default: begin
                sd_d = SD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fault_q <= 1'b0;
            sd_q <= SD_IDLE;
        end else begin
            fault_q <= fault_d;
            sd_q <= sd_d;
        end
    end

    assign fp_fault_break_pending_out_n = fp_pin_q;
    assign internal_fault_out_n = fault_q ? 1'b0 : FAULT_PIN_RESET;
    assign shutdown_req = (sd_q == SD_REQ);

    snoop_result_drive u_snoop (
        .core_clk(core_clk),
        .rst(rst),
        .snoop_phase(snoop_phase),
        .snoop_req(snoop_req),
        .stall_seen(snoop_stall_seen),
        .snoop_share_in_n(snoop_share_in_n),
        .snoop_dirty_result_in_n(snoop_dirty_result_in_n),
        .pins(snoop_pins)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // fp error / break pending pin
    chk_fp_error_shown: assert property (
        !stop_active && fp_error && !fp_error_masked |=> !fp_fault_break_pending_out_n)
        else $error("unmasked fp error not shown");

    chk_fp_masked_quiet: assert property (
        !stop_active && (!fp_error || fp_error_masked) |=> fp_fault_break_pending_out_n)
        else $error("fp pin asserted without unmasked error");

    chk_fp_run_exact: assert property (
        !stop_active |=> fp_fault_break_pending_out_n == !$past(fp_unmasked))
        else $error("fp pin does not follow unmasked error");

    chk_break_ignored: assert property (
        !stop_active && break_pending && !fp_unmasked |=> fp_fault_break_pending_out_n)
        else $error("break shown while stop request inactive");

    chk_break_only: assert property (
        stop_active |=> fp_fault_break_pending_out_n == !$past(break_pending))
        else $error("fp pin does not follow break pending in stop");

    chk_fp_ignored_stop: assert property (
        stop_active && !break_pending && fp_unmasked
            |=> fp_fault_break_pending_out_n)
        else $error("fp error shown during stop request");

    // stop request synchroniser
    chk_stop_sync_lag: assert property (
        $fell(stop_clock_request_n) ##1 !stop_clock_request_n |=> stop_active)
        else $error("stop request not seen after two flops");

    chk_stop_sync_release: assert property (
        $rose(stop_clock_request_n) ##1 stop_clock_request_n |=> !stop_active)
        else $error("stop release not seen after two flops");

    chk_stop_held: assert property (
        stop_active && !$past(stop_clock_request_n) |=> stop_active)
        else $error("stop request dropped while pin held");

    // internal fault and shutdown request
    chk_fault_set: assert property (
        internal_error |=> !internal_fault_out_n)
        else $error("internal fault pin not asserted");

    chk_fault_held: assert property (
        !internal_fault_out_n |=> !internal_fault_out_n)
        else $error("internal fault pin released before reset");

    chk_fault_quiet: assert property (
        internal_fault_out_n && !internal_error |=> internal_fault_out_n)
        else $error("internal fault pin asserted without error");

    chk_shutdown_issued: assert property (
        internal_error && sd_q == SD_IDLE |=> shutdown_req)
        else $error("no shutdown request with internal fault");

    chk_req_with_fault: assert property (
        shutdown_req |-> !internal_fault_out_n)
        else $error("shutdown requested without internal fault");

    chk_req_cause: assert property (
        $rose(shutdown_req) |-> $past(internal_error))
        else $error("shutdown request raised without error");

    chk_shutdown_holds: assert property (
        shutdown_req && !shutdown_ack |=> shutdown_req)
        else $error("shutdown request dropped before ack");

    chk_shutdown_once: assert property (
        shutdown_req && shutdown_ack |=> !shutdown_req [*3])
        else $error("shutdown request repeated");

    chk_done_sticky: assert property (
        sd_q == SD_DONE |=> sd_q == SD_DONE && !shutdown_req)
        else $error("shutdown sequence left done state before reset");

    chk_no_req_idle: assert property (
        sd_q == SD_IDLE && !internal_error |=> !shutdown_req)
        else $error("shutdown request without internal error");

    // snoop results as driven and as seen on the wired lines
    chk_joint_hit_dirty: assert property (
        snoop_phase && snoop_req.hit && snoop_req.dirty
            |=> snoop_pins.share_oe_n == OE_ON && snoop_pins.dirty_oe_n == OE_ON)
        else $error("joint hit and dirty not driven on both lines");

    chk_no_stray_share: assert property (
        snoop_phase && !snoop_req.stall && !snoop_req.hit
            |=> snoop_pins.share_oe_n == OE_OFF)
        else $error("share line driven without hit or stall");

    chk_seen_after_phase: assert property (
        $changed(snoop_stall_seen) |-> $past(snoop_phase, 4))
        else $error("stall view changed outside a snoop phase");

    cov_fp_error: cover property (!stop_active && fp_error && !fp_error_masked);
    cov_break_in_stop: cover property (stop_active && break_pending);
    cov_fault_shutdown: cover property (internal_error ##[1:20] shutdown_ack);
    cov_stop_toggle: cover property (stop_active ##[1:50] !stop_active);
endmodule

// ==== verification/system_side.sv ====
// far side model: other bus agents on the result lines, shutdown acknowledger
`timescale 1ns/1ps
module system_side
    import status_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // device side
    input snoop_pins_t pins,
    input wire logic shutdown_req,
    output logic shutdown_ack,
    // other agent stall request and wired lines
    input wire logic other_stall,
    output logic share_n,
    output logic dirty_n
);
    logic [1:0] wait_q;
    // pulled-up lines, any agent pulls low; stall drives both together
    assign share_n = !(other_stall || pins.share_oe_n == OE_ON);
    assign dirty_n = !(other_stall || pins.dirty_oe_n == OE_ON);
    // shutdown only acknowledged; no external error raised here
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_q <= 2'h0;
            shutdown_ack <= 1'b0;
        end else begin
            wait_q <= (shutdown_req && !shutdown_ack) ? wait_q + 2'h1 : 2'h0;
            shutdown_ack <= shutdown_req && !shutdown_ack && wait_q == 2'h1;
        end
    end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the status pin block
`timescale 1ns/1ps
module testbench;
    import status_pkg::*;
    logic core_clk, rst, stop_n, fp_err, fp_msk, brk, int_err, phase, other_stall;
    logic sd_req, sd_ack, seen, share_n, dirty_n, fp_n, fault_n;
    snoop_req_t sreq;
    snoop_pins_t pins;
    int num_errors = 0;
    int compares = 0;
    int st, ex;
    logic [31:0] seed = 32'h15;
    error_snoop_status DUT (.core_clk(core_clk), .rst(rst), .stop_clock_request_n(stop_n),
        .fp_error(fp_err), .fp_error_masked(fp_msk), .break_pending(brk),
        .internal_error(int_err), .shutdown_req(sd_req), .shutdown_ack(sd_ack),
        .snoop_phase(phase), .snoop_req(sreq), .snoop_stall_seen(seen),
        .snoop_share_in_n(share_n), .snoop_dirty_result_in_n(dirty_n),
        .snoop_pins(pins), .fp_fault_break_pending_out_n(fp_n),
        .internal_fault_out_n(fault_n));
    system_side peer (.core_clk(core_clk), .rst(rst), .pins(pins), .shutdown_req(sd_req),
        .shutdown_ack(sd_ack), .other_stall(other_stall), .share_n(share_n),
        .dirty_n(dirty_n));
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk(logic [3:0] got, logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %b expected %b", $time, got, exp);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // whole run is about two hundred cycles, a tenth of this limit
    initial begin
        #20000;
        num_errors++;
        end_sim();
    end
    initial begin
        {rst, stop_n, fp_err, fp_msk, brk, int_err, phase, other_stall} = 8'h C0;
        sreq = '0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        chk({fp_n, fault_n, sd_req, seen}, 4'hC);
        // held four cycles to cover the stop pin synchroniser
        repeat (32) begin
            seed = xs(seed);
            {stop_n, fp_err, fp_msk, brk} = seed[3:0];
            tick(4);
            ex = stop_n ? !(fp_err && !fp_msk) : !brk;
            chk({3'h0, fp_n}, 4'(ex));
        end
        // break seen during stop: system returns the core to normal
        if (fp_n === 1'b0 && stop_n === 1'b0) stop_n = 1'b1;
        $display("test fp pin done");
        int_err = 1'b1;
        tick(1);
        int_err = 1'b0;
        chk({2'h0, fault_n, sd_req}, 4'h1);
        tick(4);
        chk({2'h0, fault_n, sd_req}, 4'h0);
        int_err = 1'b1;
        tick(1);
        int_err = 1'b0;
        tick(3);
        chk({2'h0, fault_n, sd_req}, 4'h0);
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        tick(1);
        chk({2'h0, fault_n, sd_req}, 4'h2);
        $display("test fault done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            other_stall = seed[0];
            sreq = i[2:0];
            phase = 1'b1;
            tick(1);
            phase = 1'b0;
            st = i[2];
            ex = {OD_DRIVE_LEVEL, !(st || i[1]), OD_DRIVE_LEVEL, !(st || i[0])};
            chk(pins, 4'(ex));
            // request still present without a phase must not drive
            tick(1);
            chk({pins.share_oe_n, pins.dirty_oe_n}, {2'h0, OE_OFF, OE_OFF});
            tick(4);
            chk({3'h0, seen}, 4'(st || (i[1] && i[0]) || other_stall));
        end
        $display("test snoop done");
        end_sim();
    end
endmodule
